// *** src/vcr_cap_regs.sv ***
// vc capability registers, table access and port channel arbiter
`timescale 1ns/10ps
module vcr_cap_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // configuration access
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [vcr_pkg::ADDR_W-1:0] cfgAddr,
    input wire logic [vcr_pkg::DATA_W-1:0] cfgWrData,
    input wire logic [vcr_pkg::BE_W-1:0] cfgByteEn,
    output logic [vcr_pkg::DATA_W-1:0] cfgRdData,
    output logic cfgRdValid,
    // general control
    input wire logic strictPriorityEn,
    // port channel arbitration
    input wire logic reqVc0,
    input wire logic reqExt,
    output logic grantVc0,
    output logic grantExt
);
    import vcr_pkg::*;

    // ------------------------------------------------------------------------
    // read decode, first stage
    // ------------------------------------------------------------------------
    logic s1Valid_reg;
    logic s1Valid_next;
    logic s1Table_reg;
    logic s1Table_next;
    logic [DATA_W-1:0] s1Const_reg;
    logic [DATA_W-1:0] s1Const_next;
    logic tableWrEn;
    logic [DATA_W-1:0] tableRdA;
    logic [DATA_W-1:0] tableRdB;

    always_comb
    begin
        s1Valid_next = cfgRead;
        s1Table_next = cfgRead && tableHit(cfgAddr);
        s1Const_next = ZERO_WORD;
        if (cfgRead)
        begin
            if (wordHit(cfgAddr, OFF_CAP_ID))
            begin
                s1Const_next = headerWord();
            end
            else if (wordHit(cfgAddr, OFF_PORT_CAP1))
            begin
                s1Const_next = portCap1(strictPriorityEn);
            end
            else if (wordHit(cfgAddr, OFF_PORT_CAP2))
            begin
                s1Const_next = portCap2(strictPriorityEn);
            end
        end
    end

    // capability words are built from constants and the strict input, never from stored data
    assign tableWrEn = cfgWrite && tableHit(cfgAddr);

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1Valid_reg <= 1'b0;
            s1Table_reg <= 1'b0;
            s1Const_reg <= ZERO_WORD;
        end
        else
        begin
            s1Valid_reg <= s1Valid_next;
            s1Table_reg <= s1Table_next;
            s1Const_reg <= s1Const_next;
        end
    end

    // ------------------------------------------------------------------------
    // read answer, second stage
    // ------------------------------------------------------------------------
    logic [DATA_W-1:0] rdData_reg;
    logic [DATA_W-1:0] rdData_next;
    logic rdValid_reg;
    logic rdValid_next;

    always_comb
    begin
        rdValid_next = s1Valid_reg;
        rdData_next = s1Table_reg ? tableRdA : s1Const_reg;
        if (!s1Valid_reg)
        begin
            rdData_next = ZERO_WORD;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData_reg <= ZERO_WORD;
            rdValid_reg <= 1'b0;
        end
        else
        begin
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    assign cfgRdData = rdData_reg;
    assign cfgRdValid = rdValid_reg;

    // ------------------------------------------------------------------------
    // arbitration table
    // ------------------------------------------------------------------------
    logic [PHASE_W-1:0] phase_reg;
    logic [PHASE_W-1:0] phase_next;
    logic [ENTRY_W-1:0] entry;
    logic preferExt;

    vcr_table_mem #(
        .WIDTH(DATA_W),
        .DEPTH(TABLE_WORDS),
        .AW(TABLE_AW)
    ) u_table (
        .clk(ref_clk),
        .resetn(resetn),
        .wrEn(tableWrEn),
        .wrAddr(cfgAddr[TABLE_AW+1:2]),
        .wrData(cfgWrData),
        .wrByteEn(cfgByteEn),
        .rdAddrA(cfgAddr[TABLE_AW+1:2]),
        .rdDataA(tableRdA),
        .rdAddrB(phase_next[PHASE_W-1:PHASE_W-TABLE_AW]),
        .rdDataB(tableRdB)
    );

    // ------------------------------------------------------------------------
    // port channel arbiter
    // ------------------------------------------------------------------------
    assign entry = tableRdB[phase_reg[2:0]*ENTRY_W +: ENTRY_W];
    assign preferExt = entry[0];

    always_comb
    begin
        grantVc0 = 1'b0;
        grantExt = 1'b0;
        if (strictPriorityEn)
        begin
            grantExt = reqExt;
            grantVc0 = reqVc0 && !reqExt;
        end
        else if (preferExt)
        begin
            grantExt = reqExt;
            grantVc0 = reqVc0 && !reqExt;
        end
        else
        begin
            grantVc0 = reqVc0;
            grantExt = reqExt && !reqVc0;
        end
    end

    // work-conserving: a phase owner with nothing queued yields the slot
    always_comb
    begin
        phase_next = phase_reg;
        if (!strictPriorityEn && (grantVc0 || grantExt))
        begin
            phase_next = PHASE_W'(phase_reg + 1'b1);
        end
        // table is scratch pad in strict mode; phase frozen
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phase_reg <= '0;
        end
        else
        begin
            phase_reg <= phase_next;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence readHeader;
        cfgRead && wordHit(cfgAddr, OFF_CAP_ID);
    endsequence

    sequence readCap1;
        cfgRead && wordHit(cfgAddr, OFF_PORT_CAP1);
    endsequence

    sequence readCap2;
        cfgRead && wordHit(cfgAddr, OFF_PORT_CAP2);
    endsequence

    sequence answerTwoLater;
        ##2 cfgRdValid;
    endsequence

    next_ptr_zero_a: assert property (
        readHeader |-> answerTwoLater ##0 (cfgRdData[31:20] == 12'h000))
        else $error("next pointer not zero");

    cap_version_a: assert property (
        readHeader |-> ##2 (cfgRdValid && cfgRdData[31:16] == 16'h0001))
        else $error("capability version word wrong");

    entry_size_a: assert property (
        readCap1 |-> ##2 (cfgRdValid && cfgRdData[11:10] == 2'b10))
        else $error("entry size field wrong");

    timer_ref_a: assert property (
        readCap1 |-> ##2 (cfgRdValid && cfgRdData[9:8] == 2'b00))
        else $error("timer reference field wrong");

    low_prio_count_a: assert property (
        readCap1 |-> ##2 (cfgRdData[6:4] ==
            ($past(strictPriorityEn, 2) ? 3'b000 : 3'b001)))
        else $error("low priority count wrong");

    strict_ext_wins_a: assert property (
        (strictPriorityEn && reqExt) |-> (grantExt && !grantVc0))
        else $error("extended channel lost in strict mode");

    ext_count_a: assert property (
        readCap1 |-> ##2 (cfgRdValid && cfgRdData[2:0] == 3'b001))
        else $error("extended channel count wrong");

    table_loc_a: assert property (
        readCap2 |-> ##2 (cfgRdData[31:24] ==
            ($past(strictPriorityEn, 2) ? 8'h00 : 8'h03)))
        else $error("arbitration table location wrong");

    scratch_pad_a: assert property (
        strictPriorityEn |=> $stable(phase_reg))
        else $error("table advanced while scratch pad");

    scheme_field_a: assert property (
        readCap2 |-> ##2 (cfgRdData[7:0] ==
            ($past(strictPriorityEn, 2) ? 8'h00 : 8'h03)))
        else $error("arbitration scheme field wrong");

    reserved_zero_a: assert property (
        readCap1 |-> ##2 (cfgRdData[31:12] == 20'h0_0000 &&
            !cfgRdData[7] && !cfgRdData[3]))
        else $error("port capability one reserved bits set");

    reserved_two_a: assert property (
        readCap2 |-> ##2 (cfgRdData[23:8] == 16'h0000))
        else $error("port capability two reserved bits set");

    write_ignored_a: assert property (
        (cfgWrite && !tableHit(cfgAddr)) |=>
            ($stable(u_table.mem_reg[0]) && $stable(u_table.mem_reg[1]) &&
            $stable(u_table.mem_reg[2]) && $stable(u_table.mem_reg[3])))
        else $error("capability write reached storage");

    grant_onehot_a: assert property (
        !(grantVc0 && grantExt) && ((reqVc0 || reqExt) ==
            (grantVc0 || grantExt)))
        else $error("arbiter grant not one-hot or idle");

    strict_vc0_alone_a: assert property (
        (strictPriorityEn && reqVc0 && !reqExt) |-> grantVc0)
        else $error("vc0 not granted alone in strict mode");

    header_id_a: assert property (
        readHeader |-> ##2 (cfgRdValid && cfgRdData[15:0] == 16'h0002))
        else $error("capability id half wrong");

    valid_source_a: assert property (
        cfgRdValid |-> $past(cfgRead, 2))
        else $error("read answer without request");

    idle_data_zero_a: assert property (
        !cfgRdValid |-> (cfgRdData == 32'h0000_0000))
        else $error("read data not zero between answers");

    phase_step_a: assert property (
        (!strictPriorityEn && (grantVc0 || grantExt)) |=>
            (phase_reg == PHASE_W'($past(phase_reg) + 1'b1)))
        else $error("arbitration phase did not advance");

    phase_hold_a: assert property (
        !(reqVc0 || reqExt) |=> $stable(phase_reg))
        else $error("arbitration phase moved while idle");

    table_store_a: assert property (
        (tableWrEn && cfgByteEn == 4'hf) |=>
            (u_table.mem_reg[$past(cfgAddr[TABLE_AW+1:2])] ==
            $past(cfgWrData)))
        else $error("table word not stored");

endmodule

// *** src/vcr_pkg.sv ***
// constants, field layout and read-value functions of the vc capability block
// ----------------------------------------------------------------------------
// Behaviour
// - next-capability pointer reads zero: last entry of the extended list.
// - capability version reads 1 in low nibble, 16-bit value 0001h.
// - arbitration table entry size field reads 10b, four-bit entries.
// - timer reference field reads 00b, internal 100 ns timer.
// - low-priority count reads 001b, 000b while strict priority enabled.
// - strict priority enabled: extended channel always beats VC0 at port.
// - extended channel count field reads 001b, one extra channel.
// - table location field reads 03h, 00h when low-priority count 000b.
// - location 00h: table storage is scratch pad, no arbitration effect.
// - scheme bits: 0 round-robin, 1/2/3 WRR 32/64/128 phases, 4-7 zero.
// - reserved bits of both port capability registers always read zero.
// ----------------------------------------------------------------------------
package vcr_pkg;

    // ------------------------------------------------------------------------
    // access port geometry
    // ------------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // ------------------------------------------------------------------------
    // byte offsets in extended configuration space
    // ------------------------------------------------------------------------
    localparam logic [11:0] OFF_CAP_ID = 12'h150;
    localparam logic [11:0] OFF_NEXT_VER = 12'h152;
    localparam logic [11:0] OFF_PORT_CAP1 = 12'h154;
    localparam logic [11:0] OFF_PORT_CAP2 = 12'h158;
    localparam logic [11:0] ARB_TABLE_BYTES = 12'h030;
    localparam logic [11:0] OFF_ARB_TABLE = OFF_CAP_ID + ARB_TABLE_BYTES;
    localparam int TABLE_WORDS = 4;
    localparam int TABLE_AW = 2;
    localparam int PHASES = 32;
    localparam int PHASE_W = 5;
    localparam int ENTRY_W = 4;

    // ------------------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------------------
    localparam logic [15:0] CAP_ID_VALUE = 16'h0002;
    localparam int NEXT_PTR_LSB = 20;
    localparam logic [11:0] NEXT_PTR_VALUE = 12'h000;
    localparam int VERSION_LSB = 16;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [15:0] NEXT_VER_RESET = 16'h0001;
    localparam int ENTRY_SIZE_LSB = 10;
    localparam logic [1:0] ENTRY_SIZE_VALUE = 2'h2;
    localparam int TIMER_REF_LSB = 8;
    localparam logic [1:0] TIMER_REF_VALUE = 2'h0;
    localparam int LOW_PRIO_LSB = 4;
    localparam logic [2:0] LOW_PRIO_NORMAL = 3'h1;
    localparam logic [2:0] LOW_PRIO_STRICT = 3'h0;
    localparam int EXTRA_COUNT_LSB = 0;
    localparam logic [2:0] EXTRA_CHANNEL_COUNT = 3'h1;
    localparam int TABLE_LOC_LSB = 24;
    localparam logic [7:0] ARB_TABLE_LOCATION = 8'h03;
    localparam logic [7:0] ARB_TABLE_NONE = 8'h00;
    localparam int SCHEMES_LSB = 0;
    localparam int SCHEME_RR_BIT = 0;
    localparam int SCHEME_WRR32_BIT = 1;
    localparam int SCHEME_WRR64_BIT = 2;
    localparam int SCHEME_WRR128_BIT = 3;
    localparam logic [7:0] SCHEMES_NONE = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------------
    // decode and read-value functions
    // ------------------------------------------------------------------------
    function automatic logic wordHit(input logic [11:0] addr,
                                     input logic [11:0] off);
        wordHit = (addr[11:2] == off[11:2]);
    endfunction

    function automatic logic tableHit(input logic [11:0] addr);
        tableHit = (addr[11:4] == OFF_ARB_TABLE[11:4]);
    endfunction

    function automatic logic [2:0] lowPrioCount(input logic strictEn);
        lowPrioCount = strictEn ? LOW_PRIO_STRICT : LOW_PRIO_NORMAL;
    endfunction

    function automatic logic [7:0] schemeMask(input logic strictEn);
        logic [7:0] m;
        m = SCHEMES_NONE;
        m[SCHEME_RR_BIT] = 1'b1;
        m[SCHEME_WRR32_BIT] = 1'b1;
        if (lowPrioCount(strictEn) == LOW_PRIO_STRICT)
        begin
            m = SCHEMES_NONE;
        end
        schemeMask = m;
    endfunction

    function automatic logic [31:0] headerWord();
        logic [31:0] w;
        w = ZERO_WORD;
        w[15:0] = CAP_ID_VALUE;
        w[VERSION_LSB +: 4] = CAP_VERSION;
        w[NEXT_PTR_LSB +: 12] = NEXT_PTR_VALUE;
        headerWord = w;
    endfunction

    function automatic logic [31:0] portCap1(input logic strictEn);
        logic [31:0] w;
        w = ZERO_WORD;
        w[ENTRY_SIZE_LSB +: 2] = ENTRY_SIZE_VALUE;
        w[TIMER_REF_LSB +: 2] = TIMER_REF_VALUE;
        w[LOW_PRIO_LSB +: 3] = lowPrioCount(strictEn);
        w[EXTRA_COUNT_LSB +: 3] = EXTRA_CHANNEL_COUNT;
        portCap1 = w;
    endfunction

    function automatic logic [31:0] portCap2(input logic strictEn);
        logic [31:0] w;
        w = ZERO_WORD;
        w[TABLE_LOC_LSB +: 8] = ARB_TABLE_LOCATION;
        if (lowPrioCount(strictEn) == LOW_PRIO_STRICT)
        begin
            w[TABLE_LOC_LSB +: 8] = ARB_TABLE_NONE;
        end
        w[SCHEMES_LSB +: 8] = schemeMask(strictEn);
        portCap2 = w;
    endfunction

endpackage

// *** src/vcr_table_mem.sv ***
// arbitration table storage: one byte-masked write port, two registered reads
`timescale 1ns/10ps
module vcr_table_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [WIDTH/8-1:0] wrByteEn,
    // configuration read port
    input wire logic [AW-1:0] rdAddrA,
    output logic [WIDTH-1:0] rdDataA,
    // arbiter read port
    input wire logic [AW-1:0] rdAddrB,
    output logic [WIDTH-1:0] rdDataB
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];

    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem_next[i] = mem_reg[i];
        end
        if (wrEn)
        begin
            for (int b = 0; b < WIDTH/8; b++)
            begin
                if (wrByteEn[b])
                begin
                    mem_next[wrAddr][b*8 +: 8] = wrData[b*8 +: 8];
                end
            end
        end
    end

    // reset keeps the arbiter off unknown entries after power-up
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= '0;
            end
            rdDataA <= '0;
            rdDataB <= '0;
        end
        else
        begin
            mem_reg <= mem_next;
            rdDataA <= mem_reg[rdAddrA];
            rdDataB <= mem_reg[rdAddrB];
        end
    end
endmodule

// *** verification/vcr_cap_regs_test.sv ***
// self-checking testbench of the vc capability register block
`timescale 1ns/10ps
module vcr_cap_regs_test;
    import vcr_pkg::*;

    // ------------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------------
    logic refClk;
    logic resetn;
    logic cfgRead;
    logic cfgWrite;
    logic [ADDR_W-1:0] cfgAddr;
    logic [DATA_W-1:0] cfgWrData;
    logic [BE_W-1:0] cfgByteEn;
    logic [DATA_W-1:0] cfgRdData;
    logic cfgRdValid;
    logic strictPriorityEn;
    logic reqVc0;
    logic reqExt;
    logic grantVc0;
    logic grantExt;
    int errorCnt;
    int totalChecks;
    logic [11:0] regAddr [4];
    logic [31:0] expLoose [4];
    logic [31:0] expStrict [4];

    vcr_cap_regs u_dut (
        .ref_clk(refClk),
        .resetn(resetn),
        .cfgRead(cfgRead),
        .cfgWrite(cfgWrite),
        .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData),
        .cfgByteEn(cfgByteEn),
        .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid),
        .strictPriorityEn(strictPriorityEn),
        .reqVc0(reqVc0),
        .reqExt(reqExt),
        .grantVc0(grantVc0),
        .grantExt(grantExt)
    );

    // ------------------------------------------------------------------------
    // clock, verdict and watchdog
    // ------------------------------------------------------------------------
    always #20 refClk = ~refClk;

    task automatic conclude();
        if (errorCnt == 0 && totalChecks > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // whole run is well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge refClk);
        errorCnt++;
        conclude();
    end

    // ------------------------------------------------------------------------
    // compare tasks
    // ------------------------------------------------------------------------
    task automatic chkWord(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkBit(input string what, input logic exp,
                          input logic got);
        totalChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------------
    // answer lands one edge after the taking edge and stands one cycle
    task automatic rdCheck(input logic [11:0] a, input logic [31:0] exp);
        @(posedge refClk);
        cfgRead <= 1'b1;
        cfgAddr <= a;
        @(posedge refClk);
        cfgRead <= 1'b0;
        @(posedge refClk);
        #1;
        chkBit("read valid", 1'b1, cfgRdValid);
        chkWord("read data", exp, cfgRdData);
        @(posedge refClk);
        #1;
        chkBit("valid after answer", 1'b0, cfgRdValid);
        chkWord("data after answer", 32'h0000_0000, cfgRdData);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        @(posedge refClk);
        cfgWrite <= 1'b1;
        cfgAddr <= a;
        cfgWrData <= d;
        cfgByteEn <= be;
        @(posedge refClk);
        cfgWrite <= 1'b0;
    endtask

    task automatic setStrict(input logic s);
        @(posedge refClk);
        strictPriorityEn <= s;
    endtask

    // mode passed in: the strict input takes its nonblocking update later in this time step
    task automatic readAll(input logic s);
        for (int i = 0; i < 4; i++)
        begin
            rdCheck(regAddr[i], s ? expStrict[i] : expLoose[i]);
        end
    endtask

    // grants are combinational, checked each cycle the requests stand
    task automatic arb(input logic v0, input logic ex, input logic expV0,
                       input logic expEx);
        @(posedge refClk);
        reqVc0 <= v0;
        reqExt <= ex;
        repeat (6)
        begin
            #1;
            chkBit("grant vc0", expV0, grantVc0);
            chkBit("grant ext", expEx, grantExt);
            @(posedge refClk);
        end
    endtask

    task automatic fillTable(input logic [31:0] d);
        for (int i = 0; i < 4; i++)
        begin
            wr(12'h180 + 12'(4 * i), d, 4'hf);
        end
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        refClk = 1'b0;
        resetn = 1'b0;
        cfgRead = 1'b0;
        cfgWrite = 1'b0;
        cfgAddr = 12'h000;
        cfgWrData = 32'h0000_0000;
        cfgByteEn = 4'h0;
        strictPriorityEn = 1'b0;
        reqVc0 = 1'b0;
        reqExt = 1'b0;
        errorCnt = 0;
        totalChecks = 0;
        regAddr = '{12'h150, 12'h154, 12'h158, 12'h15c};
        // header word carries id 0002h below next pointer and version
        expLoose = '{32'h0001_0002, 32'h0000_0811, 32'h0300_0003,
                     32'h0000_0000};
        expStrict = '{32'h0001_0002, 32'h0000_0801, 32'h0000_0000,
                      32'h0000_0000};
        repeat (5) @(posedge refClk);
        resetn <= 1'b1;
        #1;
        chkBit("valid in reset", 1'b0, cfgRdValid);

        // constant fields, both strict settings
        readAll(1'b0);
        setStrict(1'b1);
        readAll(1'b1);
        // writes of all ones must leave every capability word unchanged
        for (int i = 0; i < 4; i++)
        begin
            wr(regAddr[i], 32'hffff_ffff, 4'hf);
        end
        readAll(1'b1);
        setStrict(1'b0);
        readAll(1'b0);

        // table-driven arbitration, table at reset is all VC0-preferred
        arb(1'b1, 1'b1, 1'b1, 1'b0);
        arb(1'b0, 1'b1, 1'b0, 1'b1);
        fillTable(32'h1111_1111);
        arb(1'b1, 1'b1, 1'b0, 1'b1);
        fillTable(32'h0000_0000);
        // byte enables on the arbitration table storage
        wr(12'h184, 32'haabb_ccdd, 4'b0101);
        rdCheck(12'h184, 32'h00bb_00dd);
        wr(12'h184, 32'h0000_0000, 4'hf);
        // strict: extended wins regardless of table contents
        setStrict(1'b1);
        arb(1'b1, 1'b1, 1'b0, 1'b1);
        arb(1'b1, 1'b0, 1'b1, 1'b0);
        fillTable(32'h1111_1111);
        arb(1'b1, 1'b1, 1'b0, 1'b1);
        rdCheck(12'h158, 32'h0000_0000);
        conclude();
    end

endmodule
